// File: temp_monitor_consts.svh
// offsets, field positions, reset values and timing counts of the monitor register bank
`ifndef TEMP_MONITOR_CONSTS_SVH
`define TEMP_MONITOR_CONSTS_SVH

// ----------------------------------------------------------------------
// pointer addresses (read and write use different pointers)
// ----------------------------------------------------------------------
`define PTR_RD_CFG 8'h03
`define PTR_RD_RATE 8'h04
`define PTR_RD_LHI 8'h05
`define PTR_RD_LLO 8'h06
`define PTR_RD_RHI 8'h07
`define PTR_WR_CFG 8'h09
`define PTR_WR_RATE 8'h0A
`define PTR_WR_LHI 8'h0B
`define PTR_WR_LLO 8'h0C
`define PTR_WR_RHI 8'h0D
`define PTR_WR_ONESHOT 8'h0F

// ----------------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------------
`define CFG_MASK_BIT 7
`define CFG_HALT_BIT 6
`define CFG_SEL_BIT 5
`define CFG_RANGE_BIT 2
`define CFG_WR_MASK 8'hE4
`define RATE_WR_MASK 8'h0F
`define RATE_CODE_FASTEST 4'h9

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CFG_RST 8'h00
`define RATE_RST 8'h08
`define LHI_RST 8'h55
`define LLO_RST 8'h00
`define RHI_RST 8'h55

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SYS_CLK_HZ 20000000
`define RATE_SLOWEST_PERIOD_S 16
`define CONV_TIME_US 15000
`define SYS_CYCLES_PER_US 20
// link address of this device; the value is arbitrary
`define DEV_ADDR_DEFAULT 7'h2A

`endif

// File: temp_monitor_pkg.sv
// types shared by the monitor register bank
`default_nettype none
package temp_monitor_pkg;
  // the five software-visible threshold/control registers
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
  } reg_bank_t;
  // one host write as it crosses from the link to the system clock
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
  } reg_write_t;
  // limit comparison results
  typedef struct packed {
    logic local_high;
    logic local_low;
    logic remote_high;
    logic remote_low;
    logic remote_open;
  } limit_flags_t;
  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_HALTED} conv_state_t;
  typedef enum logic [2:0] {LINK_IDLE, LINK_ADDR, LINK_PTR, LINK_WDATA, LINK_RDATA} link_state_t;
endpackage
`default_nettype wire

// File: temp_monitor_config_limits.sv
// configuration and limit register bank with two-wire link slave and conversion sequencer
//
// Summary of operation
// - config bit 7 set keeps the alarm output inactive; clear lets it assert.
// - the alarm inhibit bit has no effect while pin 6 is the overtemp output.
// - config bit 6 set requests shutdown; clear selects continuous conversion.
// - on halt, the running conversion finishes before shutdown is entered.
// - clearing halt resumes continuous conversion at the programmed rate.
// - while halted, a one-shot write runs exactly one conversion, then halts again.
// - continuous mode repeats conversions spaced by rate code bits 3..0.
// - codes 00h..09h give periods halving from 16 s to 0.03125 s.
// - the rate only changes idle time; conversion time stays fixed.
// - rate register resets to 08h, a 0.0625 s period.
// - config bit 5 picks pin 6: 0 alarm output, 1 second overtemp output.
// - config bit 2 picks standard or extended result range.
// - configuration register resets to 00h.
// - configuration read at pointer 03h, written at pointer 09h.
// - rate read at 04h, written at 0Ah; upper four bits read zero.
// - local high limit, read 05h, written 0Bh, resets to 55h.
// - local low limit, read 06h, written 0Ch, resets to 00h.
// - remote high limit upper byte, read 07h, written 0Dh, resets to 55h.
// - alarm mode: any of five flags sets the latch and drives pin 6 low.
// - overtemp mode: only high-limit flags drive pin 6 low.
`include "temp_monitor_consts.svh"
`default_nettype none

module temp_monitor_config_limits
  import temp_monitor_pkg::*;
#(
  parameter int SLOWEST_PERIOD_CYCLES = `RATE_SLOWEST_PERIOD_S * `SYS_CLK_HZ,
  parameter int CONV_CYCLES = `CONV_TIME_US * `SYS_CYCLES_PER_US,
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output var logic sda_out,
  output var logic sda_oe,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  input wire logic remote_below_low,
  input wire logic remote_open,
  input wire logic alert_service,
  output var logic pin6_n,
  output var logic conv_busy,
  output var logic conv_start,
  output var logic conv_halted,
  output var logic range_extended
);

  localparam int CNT_W = $clog2(SLOWEST_PERIOD_CYCLES + 1);

  // ----------------------------------------------------------------------
  // shared decoding
  // ----------------------------------------------------------------------
  // register image seen by a read pointer; unmapped pointers read zero
  function automatic logic [7:0] read_reg(input logic [7:0] ptr, input reg_bank_t r);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      `PTR_RD_CFG: v = r.cfg;
      `PTR_RD_RATE: v = r.rate;
      `PTR_RD_LHI: v = r.lhi;
      `PTR_RD_LLO: v = r.llo;
      `PTR_RD_RHI: v = r.rhi;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // new register image after a host write; reserved bits are never stored
  function automatic reg_bank_t apply_write(input reg_bank_t r, input logic [7:0] ptr,
                                            input logic [7:0] data);
    reg_bank_t n;
    n = r;
    case (ptr)
      `PTR_WR_CFG: n.cfg = data & `CFG_WR_MASK;
      `PTR_WR_RATE: n.rate = data & `RATE_WR_MASK;
      `PTR_WR_LHI: n.lhi = data;
      `PTR_WR_LLO: n.llo = data;
      `PTR_WR_RHI: n.rhi = data;
      default: n = r;
    endcase
    return n;
  endfunction

  // idle time after a conversion: period of the code minus the fixed conversion time
  function automatic logic [CNT_W-1:0] idle_of(input logic [7:0] rate);
    logic [3:0] code;
    int per;
    code = (rate[3:0] > `RATE_CODE_FASTEST) ? `RATE_CODE_FASTEST : rate[3:0];
    per = SLOWEST_PERIOD_CYCLES >> code;
    if (per > CONV_CYCLES) begin
      return CNT_W'(per - CONV_CYCLES);
    end
    return CNT_W'(1);
  endfunction

  localparam reg_bank_t REG_RST = '{cfg: `CFG_RST, rate: `RATE_RST, lhi: `LHI_RST,
                                   llo: `LLO_RST, rhi: `RHI_RST};

  // ----------------------------------------------------------------------
  // link side: bit and byte handling on the rising edge of scl
  // ----------------------------------------------------------------------
  link_state_t lst, next_lst;
  logic [7:0] shift, next_shift;
  logic [3:0] bitcnt, next_bitcnt;
  logic rw, next_rw;
  logic ack, next_ack;
  logic [7:0] ptr, next_ptr;
  logic [7:0] tx, next_tx;
  reg_bank_t mirror, next_mirror;
  reg_write_t wr_word, next_wr_word;
  logic wr_tog, next_wr_tog;
  logic start_seen, next_start_seen;
  logic sda_rise;
  logic start_tog, next_start_tog;
  logic next_sda_oe;
  logic [7:0] byte_in;

  // the link keeps its own copy of the bank so reads need no crossing;
  // both copies change only through the same writes
  always_comb begin
    byte_in = {shift[6:0], sda_in};
    next_lst = lst;
    next_shift = shift;
    next_bitcnt = bitcnt;
    next_rw = rw;
    next_ack = ack;
    next_ptr = ptr;
    next_tx = tx;
    next_mirror = mirror;
    next_wr_word = wr_word;
    next_wr_tog = wr_tog;
    next_start_seen = start_seen;
    if (start_tog != start_seen) begin
      // first bit after a start (or repeated start)
      next_start_seen = start_tog;
      next_lst = LINK_ADDR;
      next_shift = {7'h00, sda_in};
      next_bitcnt = 4'd1;
      next_ack = 1'b0;
    end else if (lst != LINK_IDLE) begin
      if (bitcnt < 4'd8) begin
        next_shift = byte_in;
        next_bitcnt = bitcnt + 4'd1;
        if (bitcnt == 4'd7) begin
          next_ack = 1'b1;
          case (lst)
            LINK_ADDR: begin
              next_ack = (byte_in[7:1] == DEV_ADDR);
              next_rw = byte_in[0];
              next_tx = read_reg(ptr, mirror);
            end
            LINK_PTR: next_ptr = byte_in;
            LINK_WDATA: begin
              next_mirror = apply_write(mirror, ptr, byte_in);
              next_wr_word = '{ptr: ptr, data: byte_in};
              next_wr_tog = ~wr_tog;
            end
            LINK_RDATA: next_ack = 1'b0; // the host acknowledges reads
            default: next_ack = 1'b0;
          endcase
        end
      end else begin
        // acknowledge slot
        next_bitcnt = 4'd0;
        next_ack = 1'b0;
        case (lst)
          LINK_ADDR: next_lst = !ack ? LINK_IDLE : (rw ? LINK_RDATA : LINK_PTR);
          LINK_PTR: next_lst = LINK_WDATA;
          LINK_RDATA: begin
            if (sda_in) begin
              next_lst = LINK_IDLE;
            end else begin
              next_tx = read_reg(ptr, mirror);
            end
          end
          default: next_lst = lst;
        endcase
      end
    end
  end

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      lst <= LINK_IDLE;
      shift <= 8'h00;
      bitcnt <= 4'd0;
      rw <= 1'b0;
      ack <= 1'b0;
      ptr <= 8'h00;
      tx <= 8'h00;
      mirror <= REG_RST;
      wr_word <= '0;
      wr_tog <= 1'b0;
      start_seen <= 1'b0;
      sda_rise <= 1'b1;
    end else begin
      lst <= next_lst;
      shift <= next_shift;
      bitcnt <= next_bitcnt;
      rw <= next_rw;
      ack <= next_ack;
      ptr <= next_ptr;
      tx <= next_tx;
      mirror <= next_mirror;
      wr_word <= next_wr_word;
      wr_tog <= next_wr_tog;
      start_seen <= next_start_seen;
      sda_rise <= sda_in;
    end
  end

  // ----------------------------------------------------------------------
  // link side: start detection and pin drive on the falling edge of scl
  // ----------------------------------------------------------------------
  // a start is sda falling while scl is high: high at the rising edge, low at
  // the falling edge; a stop is only noticed as the next start, which is
  // harmless because every write commits at its own acknowledge
  always_comb begin
    next_start_tog = start_tog;
    next_sda_oe = 1'b0;
    if (sda_rise && !sda_in) begin
      next_start_tog = ~start_tog;
    end else if (bitcnt == 4'd8 && ack) begin
      next_sda_oe = 1'b1;
    end else if (lst == LINK_RDATA && bitcnt < 4'd8) begin
      next_sda_oe = ~tx[3'(4'd7 - bitcnt)];
    end
  end

  always_ff @(negedge scl or negedge rstn) begin
    if (!rstn) begin
      start_tog <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      start_tog <= next_start_tog;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0; // open drain: only ever pulls low
    end
  end

  // ----------------------------------------------------------------------
  // crossing of host writes into the system clock
  // ----------------------------------------------------------------------
  // the write word is held for a whole byte time after the toggle, far longer
  // than the three system cycles the synchroniser needs
  logic wr_s1, wr_s2, wr_s3;
  logic wr_event;
  logic oneshot;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      wr_s3 <= 1'b0;
    end else begin
      wr_s1 <= wr_tog;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
    end
  end

  assign wr_event = wr_s2 ^ wr_s3;
  assign oneshot = wr_event && (wr_word.ptr == `PTR_WR_ONESHOT);

  // ----------------------------------------------------------------------
  // register bank, conversion sequencer and pin 6
  // ----------------------------------------------------------------------
  reg_bank_t regs, next_regs;
  conv_state_t cst, next_cst;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_conv_start;
  logic latch, next_latch;
  logic next_pin6_n;
  limit_flags_t flags;
  logic halt, any_flag, high_flag;

  assign halt = regs.cfg[`CFG_HALT_BIT];
  assign range_extended = regs.cfg[`CFG_RANGE_BIT];

  // unsigned compares suit both formats: the extended one is offset binary
  always_comb begin
    flags.local_high = local_temp > regs.lhi;
    flags.local_low = local_temp < regs.llo;
    flags.remote_high = remote_temp > regs.rhi;
    flags.remote_low = remote_below_low;
    flags.remote_open = remote_open;
  end

  assign any_flag = |flags;
  assign high_flag = flags.local_high | flags.remote_high;

  // next state of bank, sequencer and alarm
  always_comb begin
    next_regs = wr_event ? apply_write(regs, wr_word.ptr, wr_word.data) : regs;
    next_cst = cst;
    next_cnt = cnt;
    next_conv_start = 1'b0;
    case (cst)
      CONV_RUN: begin
        if (cnt <= CNT_W'(1)) begin
          if (halt) begin
            next_cst = CONV_HALTED;
          end else begin
            next_cst = CONV_IDLE;
            next_cnt = idle_of(regs.rate);
          end
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      CONV_IDLE: begin
        if (halt) begin
          next_cst = CONV_HALTED;
        end else if (cnt <= CNT_W'(1)) begin
          next_cst = CONV_RUN;
          next_cnt = CNT_W'(CONV_CYCLES);
          next_conv_start = 1'b1;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      CONV_HALTED: begin
        if (!halt || oneshot) begin
          next_cst = CONV_RUN;
          next_cnt = CNT_W'(CONV_CYCLES);
          next_conv_start = 1'b1;
        end
      end
      default: begin
        next_cst = CONV_IDLE;
        next_cnt = CNT_W'(1);
      end
    endcase
    // a new flag wins over a service in the same cycle
    next_latch = any_flag | (latch & ~alert_service);
    if (regs.cfg[`CFG_SEL_BIT]) begin
      next_pin6_n = ~high_flag;
    end else begin
      next_pin6_n = ~(next_latch & ~regs.cfg[`CFG_MASK_BIT]);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regs <= REG_RST;
      cst <= CONV_IDLE;
      cnt <= CNT_W'(1);
      conv_start <= 1'b0;
      conv_busy <= 1'b0;
      conv_halted <= 1'b0;
      latch <= 1'b0;
      pin6_n <= 1'b1;
    end else begin
      regs <= next_regs;
      cst <= next_cst;
      cnt <= next_cnt;
      conv_start <= next_conv_start;
      conv_busy <= (next_cst == CONV_RUN);
      conv_halted <= (next_cst == CONV_HALTED);
      latch <= next_latch;
      pin6_n <= next_pin6_n;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_inhibit_holds_pin;
    @(posedge sys_clk) disable iff (!rstn)
      (!regs.cfg[`CFG_SEL_BIT] && regs.cfg[`CFG_MASK_BIT]) |=> pin6_n;
  endproperty
  a_inhibit_holds_pin: assert property (p_inhibit_holds_pin) else $error("inhibited alarm low");

  property p_overtemp_ignores_inhibit;
    @(posedge sys_clk) disable iff (!rstn)
      (regs.cfg[`CFG_SEL_BIT] && high_flag) |=> !pin6_n;
  endproperty
  a_overtemp_ignores_inhibit: assert property (p_overtemp_ignores_inhibit) else $error("overtemp pin not low");

  property p_low_flags_ignored;
    @(posedge sys_clk) disable iff (!rstn)
      (regs.cfg[`CFG_SEL_BIT] && !high_flag) |=> pin6_n;
  endproperty
  a_low_flags_ignored: assert property (p_low_flags_ignored) else $error("low flag drove overtemp pin");

  property p_alarm_asserts;
    @(posedge sys_clk) disable iff (!rstn)
      (!regs.cfg[`CFG_SEL_BIT] && !regs.cfg[`CFG_MASK_BIT] && any_flag) |=> (!pin6_n && latch);
  endproperty
  a_alarm_asserts: assert property (p_alarm_asserts) else $error("alarm not asserted on flag");

  property p_finish_before_halt;
    @(posedge sys_clk) disable iff (!rstn)
      (cst == CONV_RUN && cnt > CNT_W'(1)) |=> (cst == CONV_RUN && conv_busy);
  endproperty
  a_finish_before_halt: assert property (p_finish_before_halt) else $error("conversion aborted");

  property p_resume;
    @(posedge sys_clk) disable iff (!rstn)
      (cst == CONV_HALTED && !halt) |=> (cst == CONV_RUN && conv_start && cnt == CNT_W'(CONV_CYCLES));
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after halt cleared");

  property p_oneshot;
    @(posedge sys_clk) disable iff (!rstn)
      (cst == CONV_HALTED && halt && !oneshot) |=> (cst == CONV_HALTED && !conv_start);
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("halted sequencer started unasked");

  property p_idle_length;
    @(posedge sys_clk) disable iff (!rstn)
      (cst == CONV_RUN && cnt <= CNT_W'(1) && !halt) |=> (cst == CONV_IDLE && cnt == idle_of($past(regs.rate)));
  endproperty
  a_idle_length: assert property (p_idle_length) else $error("wrong idle time");

  property p_rate_upper_zero;
    @(posedge sys_clk) disable iff (!rstn)
      wr_event |=> (regs.rate[7:4] == 4'h0 && regs.cfg[4:3] == 2'b00 && regs.cfg[1:0] == 2'b00);
  endproperty
  a_rate_upper_zero: assert property (p_rate_upper_zero) else $error("reserved bits stored");

  property p_cfg_write;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_event && wr_word.ptr == `PTR_WR_CFG) |=> (regs.cfg == ($past(wr_word.data) & `CFG_WR_MASK));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("configuration write lost");

endmodule
`default_nettype wire

// File: smbus_host.sv
// two-wire host model that reads and writes the monitor registers over the serial link
`default_nettype none
module smbus_host #(
  parameter logic [6:0] DEV = 7'h2A  // link address, value arbitrary
) (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  int nak_count = 0;
  // clock starts high with data released; after a stop the clock rests low, so the
  // next start's rising edge sees data high, which the device needs to spot the start
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_low = 1'b0;
    #24 scl = 1'b1;
    #24 sda_low = 1'b1;
    #24 scl = 1'b0;
  endtask
  // msb first; data moves a quarter period after the clock falls, so the device's
  // falling-edge start detector never mistakes a data change for a start
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #12 sda_low = ~b[i];
      #12 scl = 1'b1;
      #24 scl = 1'b0;
    end
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    if (sda !== 1'b0) nak_count++;
    #24 scl = 1'b0;
  endtask
  // one byte from the device, then a nack so it lets go of the line
  task automatic recv_byte(output logic [7:0] b);
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #24 scl = 1'b1;
      b[i] = sda;
      #24 scl = 1'b0;
    end
    #24 scl = 1'b1;
    #24 scl = 1'b0;
  endtask
  // stop: data rises while the clock is high; the clock then rests low because the
  // device only sees a start whose preceding rising edge found data high
  task automatic stop_cond();
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #24 sda_low = 1'b0;
    #24 scl = 1'b0;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    start_cond();
    send_byte({DEV, 1'b0});
    send_byte(ptr);
    send_byte(d);
    stop_cond();
  endtask
  // pointer set, repeated start, one byte read back
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    start_cond();
    send_byte({DEV, 1'b0});
    send_byte(ptr);
    start_cond();
    send_byte({DEV, 1'b1});
    recv_byte(d);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the monitor configuration and limit register bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW = 16384;
  localparam int CONV = 16;
  logic sys_clk, rstn, scl, host_low, sda_in, sda_out, sda_oe;
  logic [7:0] local_temp, remote_temp;
  logic remote_below_low, remote_open, alert_service;
  logic pin6_n, conv_busy, conv_start, conv_halted, range_extended;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int starts = 0;
  int busy_len = 0;
  // open-drain wire with pull-up: low if either side pulls
  assign sda_in = !(host_low || (sda_oe && !sda_out));
  temp_monitor_config_limits #(.SLOWEST_PERIOD_CYCLES(SLOW), .CONV_CYCLES(CONV)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .local_temp(local_temp), .remote_temp(remote_temp),
    .remote_below_low(remote_below_low), .remote_open(remote_open),
    .alert_service(alert_service), .pin6_n(pin6_n), .conv_busy(conv_busy),
    .conv_start(conv_start), .conv_halted(conv_halted), .range_extended(range_extended));
  smbus_host u_host (.scl(scl), .sda_low(host_low), .sda(sda_in));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // hang guard, well above the longest rate measurement
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      $display("FAIL at %0t: timeout", $time);
      print_verdict();
    end
  end
  // counts starts and checks every busy run, so a halt can never cut one short
  always @(negedge sys_clk) begin
    if (conv_start === 1'b1) starts++;
    if (conv_busy === 1'b1) busy_len++;
    else if (busy_len != 0) begin
      check(16'(busy_len), 16'(CONV), "conversion length");
      busy_len = 0;
    end
  end
  // ----------------------------------------------------------------------
  // helpers and scenarios
  // ----------------------------------------------------------------------
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // the sys copy lags the link by a few cycles, so settle before moving on
  task automatic put_reg(input logic [7:0] p, input logic [7:0] d);
    u_host.wr(p, d);
    wait_cycles(10);
  endtask
  // negedges up to and including the next start pulse, read off the port itself so
  // the count does not depend on the order of processes at one edge
  task automatic next_start(output int len);
    len = 0;
    do begin
      @(negedge sys_clk);
      len++;
    end while (conv_start !== 1'b1 && len < 5000);
  endtask
  // first interval may still run at the old rate, so time the second
  task automatic measure(input int exp);
    int len;
    next_start(len);
    next_start(len);
    check(16'(len), 16'(exp), "start spacing");
  endtask
  task automatic rd_check(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(p, d);
    check({8'h00, d}, {8'h00, exp}, "register read");
  endtask
  task automatic s_reset();
    rd_check(8'h03, 8'h00);
    rd_check(8'h04, 8'h08);
    rd_check(8'h05, 8'h55);
    rd_check(8'h06, 8'h00);
    rd_check(8'h07, 8'h55);
    check({15'h0, range_extended}, 16'h0000, "range at reset");
  endtask
  task automatic s_rw();
    put_reg(8'h09, 8'h04);
    put_reg(8'h0A, 8'hFC);
    put_reg(8'h0B, 8'h40);
    put_reg(8'h0C, 8'h10);
    put_reg(8'h0D, 8'h50);
    rd_check(8'h03, 8'h04);
    rd_check(8'h04, 8'h0C);
    rd_check(8'h05, 8'h40);
    rd_check(8'h06, 8'h10);
    rd_check(8'h07, 8'h50);
    check({15'h0, range_extended}, 16'h0001, "range select");
  endtask
  task automatic s_rates();
    logic [3:0] codes [3] = '{4'h5, 4'h3, 4'h9};
    for (int i = 0; i < 3; i++) begin
      put_reg(8'h0A, {4'h0, codes[i]});
      measure(SLOW >> codes[i]);
    end
  endtask
  task automatic s_halt();
    int n;
    put_reg(8'h09, 8'h44);
    wait_cycles(40);
    check({15'h0, conv_halted}, 16'h0001, "halted");
    n = starts;
    wait_cycles(100);
    check(16'(starts), 16'(n), "no starts while halted");
    put_reg(8'h0F, 8'h00);
    wait_cycles(40);
    check(16'(starts), 16'(n + 1), "one-shot count");
    check({15'h0, conv_halted}, 16'h0001, "halted after one-shot");
    put_reg(8'h09, 8'h04);
    measure(SLOW >> 9);
    check({15'h0, conv_halted}, 16'h0000, "resumed");
  endtask
  // drive the inputs, optionally pulse service, then look at pin 6
  task automatic step(input logic [7:0] lt, input logic [7:0] rt, input logic b,
                      input logic o, input logic s, input logic e);
    local_temp = lt;
    remote_temp = rt;
    remote_below_low = b;
    remote_open = o;
    alert_service = s;
    wait_cycles(1);
    alert_service = 1'b0;
    wait_cycles(2);
    check({15'h0, pin6_n}, {15'h0, e}, "pin 6 level");
  endtask
  task automatic s_alarm();
    step(8'h20, 8'h20, 1'b0, 1'b1, 1'b0, 1'b0);
    step(8'h20, 8'h20, 1'b0, 1'b0, 1'b0, 1'b0);
    step(8'h20, 8'h20, 1'b0, 1'b0, 1'b1, 1'b1);
    step(8'h08, 8'h20, 1'b0, 1'b0, 1'b0, 1'b0);
    step(8'h41, 8'h20, 1'b0, 1'b0, 1'b1, 1'b0);
    step(8'h20, 8'h51, 1'b0, 1'b0, 1'b1, 1'b0);
    step(8'h20, 8'h20, 1'b1, 1'b0, 1'b1, 1'b0);
    step(8'h20, 8'h20, 1'b0, 1'b0, 1'b1, 1'b1);
    put_reg(8'h09, 8'h84);
    step(8'h20, 8'h20, 1'b0, 1'b1, 1'b0, 1'b1);
    step(8'h20, 8'h20, 1'b0, 1'b0, 1'b1, 1'b1);
    put_reg(8'h09, 8'hA4);
    step(8'h41, 8'h20, 1'b0, 1'b0, 1'b0, 1'b0);
    step(8'h20, 8'h20, 1'b0, 1'b0, 1'b0, 1'b1);
    step(8'h08, 8'h20, 1'b1, 1'b0, 1'b0, 1'b1);
    step(8'h20, 8'h51, 1'b0, 1'b0, 1'b0, 1'b0);
    step(8'h20, 8'h20, 1'b0, 1'b0, 1'b0, 1'b1);
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    local_temp = 8'h20;
    remote_temp = 8'h20;
    remote_below_low = 1'b0;
    remote_open = 1'b0;
    alert_service = 1'b0;
    wait_cycles(12);
    rstn = 1'b1;
    s_reset();
    measure(SLOW >> 8);
    s_rw();
    measure(SLOW >> 9);
    s_rates();
    s_halt();
    s_alarm();
    check(16'(u_host.nak_count), 16'h0000, "missing acknowledge");
    print_verdict();
  end
endmodule
`default_nettype wire
